// file: prn_consts.svh
// Register offsets, field positions, reset values and timing counts for the paged register bank.
// Assumes a byte-wide host register port with 11-bit byte addresses.
`ifndef PRN_CONSTS_SVH
`define PRN_CONSTS_SVH
`define PRN_ADDR_ACCESS_CTRL   11'h2fe
`define PRN_ADDR_BANK_PTR      11'h2ff
`define PRN_ADDR_DF_BASE       11'h300
`define PRN_ADDR_DF_LAST       11'h304
`define PRN_ADDR_DF_CTRL       11'h305
`define PRN_BIT_LOCK           7
`define PRN_BIT_STATUS         0
`define PRN_BIT_READ_REQ       4
`define PRN_RST_ACCESS_CTRL    8'h00
`define PRN_RST_BANK_PTR       8'h00
`define PRN_RST_DF             40'h0000000000
`define PRN_RST_DF_CTRL        8'h00
`define PRN_CLK_MHZ            100
`define PRN_DF_GAP_US          600
`define PRN_DF_GAP_CYC         (`PRN_DF_GAP_US * `PRN_CLK_MHZ)
`define PRN_PAGE_BYTES         128
`endif

// file: prn_pkg.sv
// Types shared by the paged register bank.
// Assumes prn_consts.svh gives the numeric constants.
package prn_pkg;
   // Readback handshake states
   typedef enum logic [1:0] {
      PRN_RB_IDLE = 2'b00,  // No readback pending
      PRN_RB_WAIT = 2'b01   // Waiting for the loop to return the offset
   } prn_rb_state_t;
endpackage

// file: prn_regs.sv
// Host register bank: access lock and status, SPI page pointer, NCO delta-frequency offset.
// Assumes one-cycle host read/write strobes on clk; the loop core supplies mode and readback data.
// Host strobes and loop-core signals come from logic on clk, so nothing here is synchronised.
// Offset bytes are written one at a time and reach the synthesizers as each one lands.
// Limitation: writing all five offset bytes back to back raises the early-write flag.
// Status reports only the most recent access; read it straight after the access of interest.
// The loop core must hold rb_value valid in the cycle it pulses rb_done.
`include "prn_consts.svh"
module prn_regs #(
   parameter int unsigned DF_GAP_CYC = `PRN_DF_GAP_CYC  // Least cycles between offset writes
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Host register port
   input  wire logic [10:0] host_addr,
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata,
   output logic             host_rvalid,
   // Loop core side
   input  wire logic        nco_mode,
   input  wire logic        rb_done,
   input  wire logic [39:0] rb_value,
   output logic      [39:0] nco_delta_frequency_0,
   output logic             nco_delta_valid,
   output logic             rb_request,
   // Page routing
   output logic      [7:0]  spi_page,
   output logic             spi_page_reserved,
   output logic             df_write_early
);
   // Register state
   // Every host-visible bit lives in a _q flip-flop; the matching _d is its next value.
   // Outputs are driven straight from these flip-flops so the loop core sees no glitches.
   logic                  lock_q,    lock_d;     // Write-lock bit
   logic                  status_q,  status_d;   // Access-failure bit
   logic [7:0]            page_q,    page_d;     // Page pointer
   logic [39:0]           df_q,      df_d;       // Delta frequency offset
   logic                  rbreq_q,   rbreq_d;    // Readback request bit
   logic [7:0]            rdata_q,   rdata_d;    // Read data
   logic                  rvalid_q,  rvalid_d;   // Read data valid
   logic                  pres_q,    pres_d;     // Reserved page flag
   logic                  early_q,   early_d;    // Offset write too soon flag
   logic                  dvalid_q,  dvalid_d;   // Offset valid in NCO mode
   logic [31:0]           gap_q,     gap_d;      // Cycles since last offset write
   prn_pkg::prn_rb_state_t rb_q,     rb_d;       // Readback state
   logic                  in_df;                 // Address lies in offset bytes
   logic [2:0]            df_idx;                // Offset byte index
   logic                  fail;                  // Attempted access failed

   // Offset byte window decode; byte 0 holds bits 7:0, byte 4 bits 39:32
   // The cast keeps only the lane number; it is used only while in_df is high
   assign in_df  = (host_addr >= `PRN_ADDR_DF_BASE) && (host_addr <= `PRN_ADDR_DF_LAST);
   assign df_idx = 3'(host_addr - `PRN_ADDR_DF_BASE);

   // Page pointer is reserved at 0x07, 0x09 and 0x0e upward
   // Reserved pages are still stored; only the flag warns the page router
   function automatic logic page_bad(input logic [7:0] p);
      page_bad = (p == 8'h07) || (p == 8'h09) || (p >= 8'h0e);
   endfunction

   // Next-state logic for all host registers
   // Defaults hold every register except rvalid (clears), dvalid (follows nco_mode), the gap counter (counts) and pres (set from page_d);
   // strobes and the readback answer then override.
   // The gap counter saturates so it never wraps into a false short gap.
   always_comb begin
      lock_d   = lock_q;
      status_d = status_q;
      page_d   = page_q;
      df_d     = df_q;
      rbreq_d  = rbreq_q;
      rb_d     = rb_q;
      rdata_d  = rdata_q;
      rvalid_d = 1'b0;
      early_d  = early_q;
      dvalid_d = nco_mode;
      fail     = 1'b0;
      // Cycles since the last offset byte write, saturating
      gap_d    = (gap_q < DF_GAP_CYC) ? gap_q + 32'h1 : gap_q;
      // Host writes
      if (host_wr) begin
         if (host_addr == `PRN_ADDR_ACCESS_CTRL) begin
            // Lock bit itself stays writable so the lock can be released
            // Status is not writable; it only reports the outcome of each access
            lock_d = host_wdata[`PRN_BIT_LOCK];
         end else if (lock_q) begin
            // Locked: every other register keeps its value
            fail = 1'b1;
         end else if (host_addr == `PRN_ADDR_BANK_PTR) begin
            // Any value is stored; reserved ones only raise the flag
            page_d = host_wdata;
         end else if (in_df) begin
            // A pending readback owns the offset; a host write would race it
            if (rbreq_q) begin
               fail = 1'b1;
            end else begin
               df_d[df_idx*8 +: 8] = host_wdata;
               // Early writes are still taken; the sticky flag tells software
               if (gap_q < DF_GAP_CYC) begin
                  early_d = 1'b1;
               end
               gap_d = 32'h0;
            end
         end else if (host_addr == `PRN_ADDR_DF_CTRL) begin
            // Only the host may set the request; a repeat while pending is ignored
            if (host_wdata[`PRN_BIT_READ_REQ] && !rbreq_q) begin
               rbreq_d = 1'b1;
               rb_d    = prn_pkg::PRN_RB_WAIT;
            end
         end else begin
            // Unmapped address: nothing is stored
            fail = 1'b1;
         end
      end
      // Host reads
      // Read data is registered, so it appears one cycle after the strobe
      if (host_rd) begin
         rvalid_d = 1'b1;
         if (host_addr == `PRN_ADDR_ACCESS_CTRL) begin
            // Reserved bits read as zero
            rdata_d = {lock_q, 6'h00, status_q};
         end else if (host_addr == `PRN_ADDR_BANK_PTR) begin
            // Page pointer reads back as written
            rdata_d = page_q;
         end else if (in_df) begin
            // One offset byte per address
            rdata_d = df_q[df_idx*8 +: 8];
         end else if (host_addr == `PRN_ADDR_DF_CTRL) begin
            // Only the request bit is modelled; the rest read as zero
            rdata_d = {3'h0, rbreq_q, 4'h0};
         end else begin
            // Unmapped address reads as zero and counts as a failed access
            rdata_d = 8'h00;
            fail    = 1'b1;
         end
      end
      // Readback completion: device loads offset and clears request on the same edge
      // The request bit stays high until the value is in place, so a host
      // that polls for zero always reads the returned offset afterwards.
      // The returned value replaces all five bytes at once.
      case (rb_q)
         prn_pkg::PRN_RB_WAIT: begin
            if (rb_done) begin
               df_d    = rb_value;
               rbreq_d = 1'b0;
               rb_d    = prn_pkg::PRN_RB_IDLE;
            end
         end
         default: rb_d = rb_d;
      endcase
      // Every access records its own outcome in the status bit
      // A failure in either strobe of the cycle wins over a success
      if (host_wr || host_rd) begin
         status_d = fail;
      end
      // Flag follows the pointer's next value so both change on one edge
      pres_d = page_bad(page_d);
   end

   // Register update
   // Synchronous reset: every register returns to its documented default
   // The gap counter starts saturated so the first offset write is never early
   // dvalid follows nco_mode one cycle late, like every other output
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_q   <= 1'b0;
         status_q <= 1'b0;
         page_q   <= `PRN_RST_BANK_PTR;
         df_q     <= `PRN_RST_DF;
         rbreq_q  <= 1'b0;
         rb_q     <= prn_pkg::PRN_RB_IDLE;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
         pres_q   <= 1'b0;
         early_q  <= 1'b0;
         dvalid_q <= 1'b0;
         gap_q    <= DF_GAP_CYC;
      end else begin
         lock_q   <= lock_d;
         status_q <= status_d;
         page_q   <= page_d;
         df_q     <= df_d;
         rbreq_q  <= rbreq_d;
         rb_q     <= rb_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         pres_q   <= pres_d;
         early_q  <= early_d;
         gap_q    <= gap_d;
         dvalid_q <= dvalid_d;
      end
   end

   // Outputs straight from flip-flops
   // The synthesizers apply f = nominal*(1 - X/2^40) to the offset while
   // nco_delta_valid is high; a negative X raises the output frequency.
   // A stale offset stays on the port when the mode drops; only the valid bit follows.
   assign host_rdata            = rdata_q;
   assign host_rvalid           = rvalid_q;
   assign nco_delta_frequency_0 = df_q;
   assign nco_delta_valid       = dvalid_q;
   assign rb_request            = rbreq_q;
   assign spi_page              = page_q;
   assign spi_page_reserved     = pres_q;
   assign df_write_early        = early_q;
endmodule // prn_regs

// file: prn_regs_checker.sv
// Assertions on the ports of the paged register bank.
// Assumes it is bound into prn_regs; the lock bit is mirrored from host writes.
module prn_regs_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // Host register port
   input wire logic        host_wr,
   input wire logic        host_rd,
   input wire logic [10:0] host_addr,
   input wire logic [7:0]  host_wdata,
   input wire logic [7:0]  host_rdata,
   input wire logic        host_rvalid,
   // Loop core side
   input wire logic        rb_done,
   input wire logic [39:0] rb_value,
   input wire logic        rb_request,
   input wire logic [39:0] nco_delta_frequency_0,
   // Page routing
   input wire logic [7:0]  spi_page,
   input wire logic        spi_page_reserved
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic lk_q;  // Mirror of the lock bit
   // Lock bit is always writable, so a write to its address settles it
   always_ff @(posedge clk) lk_q <= sys_rst ? 1'b0 : (host_wr && host_addr == 11'h2fe) ? host_wdata[7] : lk_q;
   a_page_open: assert property (host_wr && host_addr == 11'h2ff && !lk_q |=> spi_page == $past(host_wdata))
      else $error("page write lost");
   a_lock_hold: assert property (host_wr && host_addr == 11'h2ff && lk_q |=> $stable(spi_page))
      else $error("locked page changed");
   a_page_rsv: assert property (spi_page_reserved == (spi_page == 8'h07 || spi_page == 8'h09 || spi_page > 8'h0d))
      else $error("reserved flag wrong");
   a_fail_flag: assert property (host_wr && lk_q && host_addr == 11'h2ff
      ##1 !host_wr && !host_rd ##1 host_rd && !host_wr && host_addr == 11'h2fe |=> host_rdata[0])
      else $error("refused write not flagged");
   a_ok_clears: assert property (host_wr && !host_rd && host_addr == 11'h2fe
      ##1 !host_wr && !host_rd ##1 host_rd && !host_wr && host_addr == 11'h2fe |=> !host_rdata[0])
      else $error("status kept after good access");
   a_unmapped_zero: assert property (host_rd && host_addr < 11'h2fe |=> host_rvalid && host_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rb_set: assert property (host_wr && host_addr == 11'h305 && host_wdata[4] && !lk_q && !rb_request |=> rb_request)
      else $error("readback not requested");
   a_rb_load: assert property (rb_done && rb_request |=> nco_delta_frequency_0 == $past(rb_value) && !rb_request)
      else $error("readback not loaded");
   a_df_byte: assert property (host_wr && host_addr == 11'h300 && !lk_q && !rb_request
      |=> nco_delta_frequency_0[7:0] == $past(host_wdata))
      else $error("offset byte lost");
endmodule // prn_regs_checker
bind prn_regs prn_regs_checker u_chk (.clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
   .host_rvalid(host_rvalid), .rb_done(rb_done), .rb_request(rb_request), .spi_page_reserved(spi_page_reserved),
   .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .spi_page(spi_page),
   .rb_value(rb_value), .nco_delta_frequency_0(nco_delta_frequency_0));

// file: prn_loop_model.sv
// Loop core model answering offset readback requests.
// Assumes the request is a level that drops after the answer pulse.
module prn_loop_model #(
   parameter int          DLY = 3,                  // Cycles counted before answering; the pulse comes one cycle later
   parameter logic [39:0] VAL = 40'h80_0000_0001    // Returned offset
) (
   // Clock
   input wire logic        clk,
   // Readback handshake
   input wire logic        rb_request,
   output logic            rb_done = 1'b0,
   output logic     [39:0] rb_value
);
   int n = 0;  // Cycles spent on the pending request
   // One-cycle answer pulse after the delay
   always @(posedge clk) begin
      n <= rb_request && !rb_done ? n + 1 : 0;
      rb_done <= rb_request && n == DLY;
   end
   // Data is only meaningful with the pulse
   assign rb_value = rb_done ? VAL : ~VAL;
endmodule // prn_loop_model

// file: paged_regs_nco_offset_test.sv
// Self-checking bench for the paged register bank.
// Assumes a shortened offset-write gap and the loop model on the core side.
module paged_regs_nco_offset_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, sys_rst = 1, host_wr = 0, host_rd = 0, nco_mode = 0, rb_done, rb_request, host_rvalid, nva, rsv, early;
   logic [10:0] host_addr = 0;
   logic [7:0] host_wdata = 0, host_rdata, spi_page;
   logic [39:0] rb_value, df;
   int n_errors = 0, samples_checked = 0, cyc = 0;
   localparam logic [39:0] RB_VAL = 40'h80_0000_0001;
   localparam int GAP = 20;  // Shortened offset-write gap
   always #5 clk = ~clk;
   prn_regs #(.DF_GAP_CYC(GAP)) dut (.clk(clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .nco_mode(nco_mode), .rb_done(rb_done), .rb_value(rb_value), .nco_delta_frequency_0(df),
      .nco_delta_valid(nva), .rb_request(rb_request), .spi_page(spi_page), .spi_page_reserved(rsv),
      .df_write_early(early));
   prn_loop_model #(.VAL(RB_VAL)) loop (.clk(clk), .rb_request(rb_request), .rb_done(rb_done), .rb_value(rb_value));
   task automatic chk(input logic [40:0] g, e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk) {host_addr, host_wdata, host_wr} <= {a, d, 1'b1};
      @(posedge clk) host_wr <= 0;
      #1;
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      @(posedge clk) {host_addr, host_rd} <= {a, 1'b1};
      @(posedge clk) host_rd <= 0;
      #1 chk({host_rvalid, host_rdata}, {1'b1, e});
   endtask
   task automatic t_reset;
      rd(11'h2fe, 8'h00);
      rd(11'h2ff, 8'h00);
      rd(11'h100, 8'h00);
      chk(nva, 1'b0);
   endtask
   task automatic t_pages;
      logic [7:0] p[8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'hff, 8'h0d, 8'h0e};
      logic       r[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      foreach (p[i]) begin
         wr(11'h2ff, p[i]);
         chk({rsv, spi_page}, {r[i], p[i]});
      end
   endtask
   task automatic t_lock;
      wr(11'h2fe, 8'h80);
      wr(11'h2ff, 8'h03);
      chk(spi_page, 8'h0e);
      rd(11'h2fe, 8'h81);
      rd(11'h2fe, 8'h80);
      wr(11'h2fe, 8'h00);
      rd(11'h2fe, 8'h00);
      wr(11'h2ff, 8'h03);
      chk(spi_page, 8'h03);
   endtask
   task automatic t_offset;
      wr(11'h300, 8'h01);
      repeat (GAP) @(posedge clk);
      wr(11'h301, 8'h02);
      chk(early, 1'b0);
      // Remaining bytes back to back break the gap on purpose to raise the flag
      wr(11'h302, 8'h03);
      wr(11'h303, 8'h04);
      wr(11'h304, 8'h01);
      chk(df, 40'h01_0403_0201);
      chk(early, 1'b1);
      rd(11'h304, 8'h01);
   endtask
   task automatic t_readback;
      @(posedge clk) nco_mode <= 1;
      wr(11'h305, 8'h10);
      chk(rb_request, 1'b1);
      for (int i = 0; i < 20 && rb_request; i++) @(posedge clk) #1;
      chk({rb_request, df}, {1'b0, RB_VAL});
      chk(nva, 1'b1);
   endtask
   task automatic t_reset_again;
      @(posedge clk) sys_rst <= 1;
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      #1 chk({early, rb_request, nva, spi_page}, 11'h000);
      chk(df, 40'h00_0000_0000);
      rd(11'h2fe, 8'h00);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      t_reset;
      t_pages;
      t_lock;
      t_offset;
      t_readback;
      t_reset_again;
      tally_and_finish;
   end
   always @(posedge clk) if (++cyc > 1000) begin
      n_errors++;
      tally_and_finish;
   end
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
endmodule // paged_regs_nco_offset_test
